// ===== rtl/edge_irq_pkg.sv
package edge_irq_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          NUM_CH          = 4;
    // register word indices; byte address is four times the index
    localparam logic [7:0]  IDX_CTRL_LOW    = 8'h3F;
    localparam logic [7:0]  IDX_CTRL_HIGH   = 8'h40;
    localparam logic [7:0]  IDX_PRIORITY    = 8'h7B;
    localparam logic [7:0]  IDX_PIN_STATE   = 8'h41;
    localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h42;
    localparam logic [7:0]  IDX_IRQ_MASK    = 8'h43;
    // control register field positions, per pair
    localparam int          HI_FLAG_BIT     = 7;
    localparam int          HI_POL_LSB      = 5;
    localparam int          HI_EN_BIT       = 4;
    localparam int          LO_FLAG_BIT     = 3;
    localparam int          LO_POL_LSB      = 1;
    localparam int          LO_EN_BIT       = 0;
    // priority register fields
    localparam int          LINE_A_LVL_LSB  = 0;
    localparam int          LINE_B_LVL_LSB  = 2;
    // vector words (read-only information)
    localparam logic [15:0] VEC_LINE_A      = 16'hFFFA;
    localparam logic [15:0] VEC_LINE_B      = 16'hFFF8;
    // reset values
    localparam logic [7:0]  CTRL_RST        = 8'h00;
    localparam logic [3:0]  PRIORITY_RST    = 4'hF;
    localparam logic [1:0]  STAT_RST        = 2'h0;
    // polarity encodings
    localparam logic [1:0]  POL_NONE        = 2'h0;
    localparam logic [1:0]  POL_RISE        = 2'h1;
    localparam logic [1:0]  POL_FALL        = 2'h2;
    localparam logic [1:0]  POL_BOTH        = 2'h3;
endpackage : edge_irq_pkg

// ===== rtl/edge_external_interrupt.sv
// What this block does
// - matching edge sets the channel request flag
// - flag and enable both set raise request
// - writing zero to a flag clears it
// - flag sets regardless of enable bit
// - enable rising with flag set requests immediately
// - two-bit level fields prioritise both lines
// - asserted request can wake from stop
// - pin levels stay readable while used
// - control register bit layout, first at 3F
// - polarity codes none, rise, fall, both
// - writing one to a flag does nothing
// - channels 0,1 line a; 2,3 line b
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module edge_external_interrupt
    import edge_irq_pkg::*;
(
    input  wire logic                          sys_clk,       // 10 MHz system clock
    input  wire logic                          rst_b,         // async reset, active low
    input  wire logic [edge_irq_pkg::ADDR_W-1:0] address,     // word address
    input  wire logic                          read,          // read strobe
    input  wire logic                          write,         // write strobe
    input  wire logic [3:0]                    byteenable,    // byte lanes
    input  wire logic [edge_irq_pkg::DATA_W-1:0] writedata,   // write data
    output logic      [edge_irq_pkg::DATA_W-1:0] readdata,    // read data
    output logic                               waitrequest,   // stall
    input  wire logic [edge_irq_pkg::NUM_CH-1:0] edge_pin,    // interrupt pins
    output logic                               request_line_a, // channels 0 and 1
    output logic                               request_line_b, // channels 2 and 3
    output logic [1:0]                         line_a_level,  // priority for line a
    output logic [1:0]                         line_b_level,  // priority for line b
    output logic                               stop_wake,     // wake from stop
    output logic                               irq            // summary interrupt
);
    import edge_irq_pkg::*;

    typedef struct packed {
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        logic [3:0]  prev;
        logic [3:0]  flag;
        logic [7:0]  pol;
        logic [3:0]  en;
        logic [3:0]  prio;
        logic [1:0]  stat;
        logic [1:0]  mask;
        logic        ack;
        logic [31:0] rdata;
        logic        line_a;
        logic        line_b;
        logic        irq;
    } state_t;

    state_t state_reg;
    state_t state_next;

    function automatic logic edge_hit(input logic [1:0] pol, input logic prev, input logic cur);
        logic rise;
        logic fall;
        rise = ~prev & cur;
        fall = prev & ~cur;
        unique case (pol)
            POL_NONE: edge_hit = 1'b0;
            POL_RISE: edge_hit = rise;
            POL_FALL: edge_hit = fall;
            POL_BOTH: edge_hit = rise | fall;
        endcase
    endfunction : edge_hit

    function automatic logic [7:0] ctrl_pack(input logic [1:0] fl, input logic [3:0] pl, input logic [1:0] e);
        logic [7:0] v;
        v = 8'h00;
        v[HI_FLAG_BIT] = fl[1];
        v[HI_POL_LSB+:2] = pl[3:2];
        v[HI_EN_BIT] = e[1];
        v[LO_FLAG_BIT] = fl[0];
        v[LO_POL_LSB+:2] = pl[1:0];
        v[LO_EN_BIT] = e[0];
        ctrl_pack = v;
    endfunction : ctrl_pack

    logic [3:0] hit;
    logic [3:0] clr;
    logic       req;
    logic       wr;
    logic       rd;
    logic [7:0] wd;

    always_comb begin
        state_next = state_reg;
        req = (read | write) & ~state_reg.ack;
        // writes land on the edge after the wait state, when waitrequest is sampled low
        wr = write & state_reg.ack & byteenable[0];
        rd = read & req;
        wd = writedata[7:0];
        state_next.ack = req;
        state_next.sync1 = edge_pin;
        state_next.sync2 = state_reg.sync1;
        state_next.prev = state_reg.sync2;
        for (int i = 0; i < NUM_CH; i++) begin
            hit[i] = edge_hit(state_reg.pol[2*i+:2], state_reg.prev[i], state_reg.sync2[i]);
        end
        clr = 4'h0;
        if (wr && address == IDX_CTRL_LOW) begin
            clr[0] = ~wd[LO_FLAG_BIT];
            clr[1] = ~wd[HI_FLAG_BIT];
            state_next.pol[3:0] = {wd[HI_POL_LSB+:2], wd[LO_POL_LSB+:2]};
            state_next.en[1:0] = {wd[HI_EN_BIT], wd[LO_EN_BIT]};
        end
        if (wr && address == IDX_CTRL_HIGH) begin
            clr[2] = ~wd[LO_FLAG_BIT];
            clr[3] = ~wd[HI_FLAG_BIT];
            state_next.pol[7:4] = {wd[HI_POL_LSB+:2], wd[LO_POL_LSB+:2]};
            state_next.en[3:2] = {wd[HI_EN_BIT], wd[LO_EN_BIT]};
        end
        if (wr && address == IDX_PRIORITY) begin
            state_next.prio = wd[3:0];
        end
        state_next.flag = hit | (state_reg.flag & ~clr);
        state_next.line_a = |(state_next.flag[1:0] & state_next.en[1:0]);
        state_next.line_b = |(state_next.flag[3:2] & state_next.en[3:2]);
        state_next.stat = state_reg.stat
                          & ~((wr && address == IDX_IRQ_STATUS) ? wd[1:0] : 2'h0);
        state_next.stat = state_next.stat | {state_next.line_b & ~state_reg.line_b,
                                             state_next.line_a & ~state_reg.line_a};
        if (wr && address == IDX_IRQ_MASK) begin
            state_next.mask = wd[1:0];
        end
        state_next.irq = |(state_next.stat & state_next.mask);
        state_next.rdata = 32'h0000_0000;
        if (rd) begin
            unique case (address)
                IDX_CTRL_LOW:   state_next.rdata[7:0] = ctrl_pack(state_reg.flag[1:0], state_reg.pol[3:0],
                                                                  state_reg.en[1:0]);
                IDX_CTRL_HIGH:  state_next.rdata[7:0] = ctrl_pack(state_reg.flag[3:2], state_reg.pol[7:4],
                                                                  state_reg.en[3:2]);
                IDX_PRIORITY:   state_next.rdata[3:0] = state_reg.prio;
                IDX_PIN_STATE:  state_next.rdata[3:0] = state_reg.sync2;
                IDX_IRQ_STATUS: state_next.rdata[1:0] = state_reg.stat;
                IDX_IRQ_MASK:   state_next.rdata[1:0] = state_reg.mask;
                default:        state_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '0;
            state_reg.prio <= PRIORITY_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // answer one cycle after the request is seen
    assign waitrequest    = (read | write) & ~state_reg.ack;
    assign readdata       = state_reg.rdata;
    assign request_line_a = state_reg.line_a;
    assign request_line_b = state_reg.line_b;
    assign line_a_level   = state_reg.prio[LINE_A_LVL_LSB+:2];
    assign line_b_level   = state_reg.prio[LINE_B_LVL_LSB+:2];
    assign stop_wake      = state_reg.line_a | state_reg.line_b;
    assign irq            = state_reg.irq;

    property p_line_a;
        @(posedge sys_clk) disable iff (!rst_b)
        request_line_a == |(state_reg.flag[1:0] & state_reg.en[1:0]);
    endproperty
    a_line_a: assert property (p_line_a) else $error("line a mismatch");

    property p_line_b;
        @(posedge sys_clk) disable iff (!rst_b)
        request_line_b == |(state_reg.flag[3:2] & state_reg.en[3:2]);
    endproperty
    a_line_b: assert property (p_line_b) else $error("line b mismatch");

    property p_set;
        @(posedge sys_clk) disable iff (!rst_b)
        hit[2] |=> state_reg.flag[2];
    endproperty
    a_set: assert property (p_set) else $error("flag not set on edge");

    property p_set_no_en;
        @(posedge sys_clk) disable iff (!rst_b)
        (hit[1] && !state_reg.en[1]) |=> state_reg.flag[1];
    endproperty
    a_set_no_en: assert property (p_set_no_en) else $error("flag not set while disabled");

    property p_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        (clr[1] && !hit[1]) |=> !state_reg.flag[1];
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");

    property p_write_one;
        @(posedge sys_clk) disable iff (!rst_b)
        (wr && address == IDX_CTRL_LOW && wd[HI_FLAG_BIT] && !hit[1]) |=> state_reg.flag[1] == $past(state_reg.flag[1]);
    endproperty
    a_write_one: assert property (p_write_one) else $error("write one changed flag");

    property p_enable_now;
        @(posedge sys_clk) disable iff (!rst_b)
        (state_reg.flag[1] && $rose(state_reg.en[1])) |-> request_line_a;
    endproperty
    a_enable_now: assert property (p_enable_now) else $error("no immediate request");

    property p_wake;
        @(posedge sys_clk) disable iff (!rst_b)
        (request_line_a || request_line_b) |-> stop_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");

    property p_no_pol;
        @(posedge sys_clk) disable iff (!rst_b)
        (state_reg.pol[1:0] == POL_NONE) |-> !hit[0];
    endproperty
    a_no_pol: assert property (p_no_pol) else $error("edge with detection off");

    // bus handshake steps and the channel 2 falling-edge sample
    sequence s_bus_first;
        (read || write) && waitrequest;
    endsequence

    sequence s_bus_done;
        !waitrequest;
    endsequence

    sequence s_ch2_fall_seen;
        (state_reg.pol[5:4] == POL_FALL) && state_reg.prev[2] && !state_reg.sync2[2];
    endsequence

    property p_one_wait;
        @(posedge sys_clk) disable iff (!rst_b)
        s_bus_first |=> s_bus_done;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state too long");

    property p_fall;
        @(posedge sys_clk) disable iff (!rst_b)
        s_ch2_fall_seen |=> state_reg.flag[2];
    endproperty
    a_fall: assert property (p_fall) else $error("falling edge missed");

    property p_rise_only;
        @(posedge sys_clk) disable iff (!rst_b)
        (state_reg.pol[5:4] == POL_RISE && state_reg.prev[2] && !state_reg.sync2[2]) |-> !hit[2];
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("fall seen in rise mode");

    property p_set_ch1;
        @(posedge sys_clk) disable iff (!rst_b)
        hit[1] |=> state_reg.flag[1];
    endproperty
    a_set_ch1: assert property (p_set_ch1) else $error("channel 1 flag not set");

    property p_clear_ch2;
        @(posedge sys_clk) disable iff (!rst_b)
        (clr[2] && !hit[2]) |=> !state_reg.flag[2];
    endproperty
    a_clear_ch2: assert property (p_clear_ch2) else $error("channel 2 flag not cleared");

    property p_set_beats_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        (hit[1] && clr[1]) |=> state_reg.flag[1];
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear beat set");

    property p_sync_chain;
        @(posedge sys_clk) disable iff (!rst_b)
        state_reg.sync2 == $past(state_reg.sync1);
    endproperty
    a_sync_chain: assert property (p_sync_chain) else $error("sync chain broken");

    property p_prev_sample;
        @(posedge sys_clk) disable iff (!rst_b)
        state_reg.prev == $past(state_reg.sync2);
    endproperty
    a_prev_sample: assert property (p_prev_sample) else $error("previous sample wrong");

    property p_pin_read;
        @(posedge sys_clk) disable iff (!rst_b)
        (rd && address == IDX_PIN_STATE) |=> readdata[3:0] == $past(state_reg.sync2);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin state read wrong");

    property p_prio_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (wr && address == IDX_PRIORITY) |=> {line_b_level, line_a_level} == $past(wd[3:0]);
    endproperty
    a_prio_write: assert property (p_prio_write) else $error("priority not written");

    property p_unmapped;
        @(posedge sys_clk) disable iff (!rst_b)
        (rd && address == 8'h10) |=> readdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_line_a_ch0;
        @(posedge sys_clk) disable iff (!rst_b)
        (state_reg.flag[0] && state_reg.en[0]) |-> request_line_a;
    endproperty
    a_line_a_ch0: assert property (p_line_a_ch0) else $error("channel 0 not on line a");

    property p_line_a_off;
        @(posedge sys_clk) disable iff (!rst_b)
        (!state_reg.en[1] && !state_reg.en[0]) |-> !request_line_a;
    endproperty
    a_line_a_off: assert property (p_line_a_off) else $error("line a without enable");

    property p_irq_rise;
        @(posedge sys_clk) disable iff (!rst_b)
        ($rose(request_line_a) && state_reg.mask[0]) |-> irq;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq missing on line a");

    property p_stat_b;
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(request_line_b) |-> state_reg.stat[1];
    endproperty
    a_stat_b: assert property (p_stat_b) else $error("line b status not set");

    property p_mask_read;
        @(posedge sys_clk) disable iff (!rst_b)
        (rd && address == IDX_IRQ_MASK) |=> readdata[1:0] == $past(state_reg.mask);
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

    property p_no_wake;
        @(posedge sys_clk) disable iff (!rst_b)
        (!request_line_a && !request_line_b) |-> !stop_wake;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("wake without request");
endmodule : edge_external_interrupt

// ===== sim/edge_source.sv
`timescale 1ns/1ps
module edge_source (
    input  wire logic       sys_clk,  // system clock
    input  wire logic [3:0] level,    // commanded pin levels
    output logic      [3:0] edge_pin  // pins seen by the block
);
    initial edge_pin = 4'h0;
    // pins move just after a clock edge and hold until told otherwise
    always @(posedge sys_clk) begin
        edge_pin <= level;
    end
endmodule : edge_source

// ===== sim/edge_external_interrupt_tb.sv
`timescale 1ns/1ps
module edge_external_interrupt_tb;
    import edge_irq_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [7:0]  address = 8'h00;
    logic [31:0] writedata = 32'h0;
    logic [31:0] rd;
    logic [3:0]  level = 4'h0;
    wire  [31:0] readdata;
    wire         waitrequest, line_a, line_b, wake, irq;
    wire  [1:0]  lva, lvb;
    wire  [3:0]  edge_pin;
    int          error_cnt = 0;
    int          checks = 0;

    always #50 sys_clk = ~sys_clk;

    edge_source SRC (.sys_clk(sys_clk), .level(level), .edge_pin(edge_pin));
    edge_external_interrupt DUT (.sys_clk(sys_clk), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .byteenable(4'hF), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .edge_pin(edge_pin), .request_line_a(line_a),
        .request_line_b(line_b), .line_a_level(lva), .line_b_level(lvb), .stop_wake(wake), .irq(irq));

    task results;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one bus cycle; request held until waitrequest is sampled low at a rising edge
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        bit ok;
        ok = 0;
        @(posedge sys_clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge sys_clk);
            ok = (waitrequest === 1'b0);
            rd = readdata;
        end
        if (!ok) begin
            error_cnt++;
            results();
        end
        read <= 1'b0;
        write <= 1'b0;
        @(negedge sys_clk);
    endtask : bus

    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdchk

    task pins(input logic [3:0] l);
        @(posedge sys_clk);
        level <= l;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : pins

    task t_reset;
        rdchk("ctrl_low", IDX_CTRL_LOW, 32'h0);
        rdchk("priority", IDX_PRIORITY, 32'hF);
        chk("levels", 32'hF, {28'h0, lvb, lva});
        bus(1'b1, IDX_PRIORITY, 32'h6);
        chk("levels", 32'h6, {28'h0, lvb, lva});
        rdchk("unmapped", 8'h10, 32'h0);
    endtask : t_reset

    task t_flag;
        bus(1'b1, IDX_CTRL_LOW, 32'h00);
        bus(1'b1, IDX_CTRL_LOW, 32'h20);
        bus(1'b1, IDX_IRQ_MASK, 32'h1);
        pins(4'h2);
        rdchk("ctrl_low", IDX_CTRL_LOW, 32'hA0);
        chk("line_a", 32'h0, line_a);
        bus(1'b1, IDX_CTRL_LOW, 32'hB0);
        rdchk("ctrl_low", IDX_CTRL_LOW, 32'hB0);
        chk("line_a", 32'h1, line_a);
        chk("wake", 32'h1, wake);
        chk("irq", 32'h1, irq);
        rdchk("status", IDX_IRQ_STATUS, 32'h1);
        bus(1'b1, IDX_IRQ_STATUS, 32'h1);
        chk("irq", 32'h0, irq);
        bus(1'b1, IDX_CTRL_LOW, 32'h30);
        chk("line_a", 32'h0, line_a);
        pins(4'h0);
        rdchk("ctrl_low", IDX_CTRL_LOW, 32'h30);
    endtask : t_flag

    task t_modes;
        logic [1:0] p;
        for (int i = 0; i < 4; i++) begin
            p = i[1:0];
            bus(1'b1, IDX_CTRL_HIGH, {27'h0, p, 1'b1});
            pins(4'h4);
            chk("line_b rise", {31'h0, p[0]}, line_b);
            chk("line_a", 32'h0, line_a);
            rdchk("pins", IDX_PIN_STATE, 32'h4);
            bus(1'b1, IDX_CTRL_HIGH, {27'h0, p, 1'b1});
            pins(4'h0);
            chk("line_b fall", {31'h0, p[1]}, line_b);
            bus(1'b1, IDX_CTRL_HIGH, 32'h0);
        end
    endtask : t_modes

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(negedge sys_clk);
        t_reset();
        t_flag();
        t_modes();
        results();
    end
endmodule : edge_external_interrupt_tb
